// >>> bench/bftm_mem.sv
// destination model: register file, data memory and io region
`timescale 1ns/1ps
module bftm_mem
  import bftm_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        dst_req,
  input  wire logic        dst_we,
  input  wire bftm_space_t dst_space,
  input  wire logic [15:0] dst_addr,
  input  wire logic [15:0] dst_wdata,
  input  wire logic        lim_in,
  output logic      [15:0] dst_rdata,
  output logic             dst_limit
);
  logic [15:0] mem_q [0:255];
  logic [7:0]  ix;
  assign ix = {dst_space, dst_addr[5:0]};
  always @(posedge mclk) if (dst_req && dst_we) mem_q[ix] <= dst_wdata;
  // read data is valid for one cycle only; the lines flip afterwards so
  // a late sample by the unit shows as a wrong value
  always @(posedge mclk) begin
    if (dst_req && !dst_we) begin
      dst_rdata <= mem_q[ix];
      dst_limit <= lim_in;
    end else begin
      dst_rdata <= ~dst_rdata;
      dst_limit <= ~dst_limit;
    end
  end
endmodule

// >>> bench/bftm_props.sv
// assertion checker for the bit-field test-and-modify unit
`timescale 1ns/1ps
module bftm_props
  import bftm_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        dst_req,
  input wire logic        dst_we,
  input wire bftm_space_t dst_space,
  input wire logic [15:0] dst_addr,
  input wire logic [15:0] dst_wdata,
  input wire logic [15:0] dst_rdata,
  input wire logic        busy,
  input wire logic [15:0] status_register
);
  // ********
  // shadow of the operand registers
  // ********
  logic        wr, st, rp, wp, nac;
  logic [2:0]  sm;
  logic [4:0]  sd;
  logic [15:0] msk_q, opd_q;
  logic [9:0]  ctl_q;
  // writes while busy are ignored by the unit, so the shadow ignores them
  assign wr  = psel & penable & pready & pwrite & ~busy;
  assign st  = wr & (paddr == CTRL_OFS) & pwdata[CTRL_START];
  assign sm  = pwdata[4:2];
  assign sd  = pwdata[9:5];
  assign nac = (sm == 3'h0) & ((sd == DEST_SR) | (sd == DEST_HWS));
  assign rp  = dst_req & ~dst_we;
  assign wp  = dst_req & dst_we;
  always_ff @(posedge mclk) if (wr && paddr == MASK_OFS) msk_q <= pwdata[15:0];
  always_ff @(posedge mclk) if (wr && paddr == OPND_OFS) opd_q <= pwdata[15:0];
  always_ff @(posedge mclk) if (st) ctl_q <= pwdata[9:0];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  AST_SHORT_SEQ: assert property (
    st && sm < 3'h3 && !nac |=> rp ##2 wp ##1 busy ##1 !busy)
    else $error("short form timing wrong");
  AST_LONG_SEQ: assert property (
    st && sm > 3'h2 |=> !dst_req [*2] ##1 rp ##2 wp ##1 busy ##1 !busy)
    else $error("long form timing wrong");
  AST_HWS_REFUSE: assert property (
    st && sm == 3'h0 && sd == DEST_HWS |=> (!busy && !dst_req) [*4])
    else $error("hardware stack destination accepted");
  AST_PAIR: assert property (
    rp |=> !dst_req ##1 (wp && dst_addr == $past(dst_addr, 2)
      && dst_space == $past(dst_space, 2)))
    else $error("read not followed by write to same place");
  AST_WDATA: assert property (
    wp |-> dst_wdata == (ctl_q[1] ? ($past(dst_rdata) & ~msk_q)
                                  : ($past(dst_rdata) ^ msk_q)))
    else $error("written value wrong");
  AST_SHORT_ADDR: assert property (
    rp && ctl_q[4:2] == 3'h1 |-> dst_space == space_xmem
      && dst_addr == {10'h000, opd_q[5:0]})
    else $error("short absolute address wrong");
  AST_IO_ADDR: assert property (
    rp && ctl_q[4:2] == 3'h2 |-> dst_space == space_io
      && dst_addr == (IO_BASE | {10'h000, opd_q[5:0]}))
    else $error("io short address wrong");
  AST_CARRY: assert property (
    wp |=> status_register[SR_C] == (($past(dst_rdata, 2) & msk_q) == msk_q))
    else $error("carry does not match test");
endmodule

bind bftm_unit bftm_props u_props (
  .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .dst_req(dst_req), .dst_we(dst_we), .dst_space(dst_space),
  .dst_addr(dst_addr), .dst_wdata(dst_wdata), .dst_rdata(dst_rdata),
  .busy(busy), .status_register(status_register)
);

// >>> bench/tb_top.sv
// self-checking bench for the bit-field test-and-modify unit
`timescale 1ns/1ps
module tb_top
  import bftm_pkg::*;
;
  logic        mclk = 1'h0;
  logic        rstn = 1'h0;
  logic        ce = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        lim_in = 1'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, dst_req, dst_we, dst_limit, busy;
  bftm_space_t dst_space;
  logic [15:0] dst_addr, dst_wdata, dst_rdata, status_register, sr;
  logic [32:0] exp_q[$], care_q[$];
  int          fail_count = 0;
  int          cmp_count = 0;
  int          seed = 20132;

  always #2.5 mclk = ~mclk;

  bftm_unit dut (
    .mclk(mclk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dst_req(dst_req),
    .dst_we(dst_we), .dst_space(dst_space), .dst_addr(dst_addr),
    .dst_wdata(dst_wdata), .dst_rdata(dst_rdata),
    .dst_limit(dst_limit), .busy(busy), .status_register(status_register)
  );
  bftm_mem u_mem (
    .mclk(mclk), .dst_req(dst_req), .dst_we(dst_we),
    .dst_space(dst_space), .dst_addr(dst_addr), .dst_wdata(dst_wdata),
    .lim_in(lim_in), .dst_rdata(dst_rdata), .dst_limit(dst_limit)
  );

  // ********
  // comparison and queue
  // ********
  task automatic check(input logic [32:0] g, input logic [32:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic pop(input logic [32:0] g);
    logic [32:0] c;
    if (exp_q.size() == 0) begin
      fail_count++;
      $display("[FAIL] %0t result with nothing expected", $time);
    end else begin
      c = care_q.pop_front();
      check(g & c, exp_q.pop_front() & c);
    end
  endtask

  always @(posedge mclk) begin
    if (dst_req === 1'h1 && dst_we === 1'h1)
      pop({17'h0, dst_wdata});
    if (psel && penable && pready === 1'h1 && !pwrite)
      pop({pslverr, prdata});
  end

  // ********
  // bus tasks
  // ********
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e,
                    input logic [32:0] c);
    exp_q.push_back(e);
    care_q.push_back(c);
    apb(1'h0, a, 32'h0);
  endtask

  task automatic run(input logic op, input logic [2:0] md,
                     input logic [4:0] ds, input logic [15:0] mk,
                     input logic [15:0] v);
    logic [15:0] r;
    logic        c, hw, sd, lg, lm;
    int          n;
    hw = md == 3'h0 && ds == DEST_HWS;
    sd = md == 3'h0 && ds == DEST_SR;
    lg = md > 3'h2;
    if (sd) v = sr;
    r = op ? (v & ~mk) : (v ^ mk);
    c = (v & mk) == mk;
    lm = 1'($random(seed));
    for (n = 0; n < 256; n++) u_mem.mem_q[n] = v;
    lim_in <= lm;
    apb(1'h1, MASK_OFS, {16'h0, mk});
    apb(1'h1, OPND_OFS, $random(seed));
    if (!hw && !sd) begin
      exp_q.push_back({17'h0, r});
      care_q.push_back({33{1'h1}});
    end
    apb(1'h1, CTRL_OFS, {22'h0, ds, md, op, 1'h1});
    n = 0;
    while (busy !== 1'h0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (hw) rd(STAT_OFS, 33'h8, 33'h1_0000_0009);
    else rd(STAT_OFS, {19'h0, (md == 3'h5) ? 2'h3 : 2'h2,
            lg ? 4'h6 : 4'h4, 4'h1, 1'h0, md == 3'h0 && lm && !sd,
            c, 1'h0}, 33'h1_FFFF_3F1F);
    if (sd) sr = r;
    else if (!hw) begin
      sr[SR_C] = c;
      if (md == 3'h0 && lm) sr[SR_L] = 1'h1;
    end
    rd(SREG_OFS, {17'h0, sr}, {33{1'h1}});
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ********
  // main sequence and watchdog
  // ********
  initial begin
    int          k;
    logic [15:0] mk, v;
    logic [4:0]  ds;
    repeat (20) @(posedge mclk);
    rstn <= 1'h1;
    @(posedge mclk);
    rd(SREG_OFS, 33'h0, {33{1'h1}});
    rd(8'h20, {1'h1, 32'h0}, {33{1'h1}});
    sr = 16'($random(seed));
    apb(1'h1, SREG_OFS, {16'h0, sr});
    apb(1'h1, R2_OFS, $random(seed));
    apb(1'h1, SP_OFS, $random(seed));
    $display("test registers done");
    for (k = 0; k < 24; k++) begin
      mk = (k == 6 || k == 13) ? 16'h0 : 16'($random(seed));
      if (k == 7) mk = 16'hFFFF;
      v = (k == 7) ? 16'hFFFF : 16'($random(seed));
      ds = 5'($random(seed));
      if (ds == DEST_SR || ds == DEST_HWS) ds = 5'h00;
      run(1'(k / 6), 3'(k % 6), ds, mk, v);
    end
    $display("test forms done");
    run(1'h1, 3'h0, DEST_SR, 16'($random(seed)), 16'h0);
    run(1'h0, 3'h0, DEST_SR, 16'($random(seed)), 16'h0);
    run(1'h1, 3'h0, DEST_HWS, 16'hFFFF, 16'h1234);
    $display("test special destinations done");
    if (exp_q.size() != 0) fail_count++;
    give_verdict();
  end

  initial begin
    #100000;
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule

// >>> rtl/bftm_addr.sv
// destination space and address for each addressing form
`timescale 1ns/1ps
module bftm_addr
  import bftm_pkg::*;
(
  input  wire bftm_mode_t  mode,
  input  wire logic [15:0] opnd,
  input  wire logic [4:0]  dest,
  input  wire logic [15:0] r2,
  input  wire logic [15:0] sp,
  output bftm_space_t      space,
  output logic      [15:0] addr
);

  always_comb begin
    space = space_xmem;
    addr  = opnd;
    case (mode)
      reg_direct_mode: begin
        space = space_reg;
        addr  = {11'h000, dest};
      end
      short_absolute_mode: begin
        addr = {10'h000, opnd[5:0]};
      end
      io_short_mode: begin
        space = space_io;
        addr  = IO_BASE | {10'h000, opnd[5:0]};
      end
      index_offset_mode: begin
        addr = r2 + {10'h000, opnd[5:0]};
      end
      stack_offset_mode: begin
        addr = sp - {10'h000, opnd[5:0]};
      end
      long_absolute_mode: begin
        addr = opnd;
      end
      default: begin
        addr = opnd;
      end
    endcase
  end

endmodule

// >>> rtl/bftm_modify.sv
// test of mask-selected bits and the inverted or cleared result
`timescale 1ns/1ps
module bftm_modify
  import bftm_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input  wire bftm_op_t          op,
  input  wire logic [DATA_W-1:0] mask,
  input  wire logic [DATA_W-1:0] din,
  output logic      [DATA_W-1:0] dout,
  output logic                   all_set
);

  // an empty mask selects nothing, so the and-reduce reads as set
  assign all_set = &(din | ~mask);

  always_comb begin
    if (op == bitfield_toggle_op) begin
      dout = din ^ mask;
    end else begin
      dout = din & ~mask;
    end
  end

endmodule

// >>> rtl/bftm_pkg.sv
// constants, types and helpers for the bit-field test-and-modify unit
package bftm_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] MASK_OFS   = 8'h04;
  localparam logic [7:0] OPND_OFS   = 8'h08;
  localparam logic [7:0] STAT_OFS   = 8'h0C;
  localparam logic [7:0] SREG_OFS   = 8'h10;
  localparam logic [7:0] R2_OFS     = 8'h14;
  localparam logic [7:0] SP_OFS     = 8'h18;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_START  = 0;
  localparam int CTRL_OP     = 1;
  localparam int CTRL_MODE   = 2;
  localparam int CTRL_DEST   = 5;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_CARRY  = 1;
  localparam int STAT_LIMIT  = 2;
  localparam int STAT_ILL    = 3;
  localparam int STAT_DONE   = 4;
  localparam int STAT_CYC    = 8;
  localparam int STAT_WORDS  = 12;
  localparam int SR_C        = 0;
  localparam int SR_L        = 6;

  // ****************************************************************
  // reset values, destination codes, address regions, timing
  // ****************************************************************
  localparam logic [15:0] SR_RESET   = 16'h0000;
  localparam logic [15:0] REG_RESET  = 16'h0000;
  localparam logic [4:0]  DEST_SR    = 5'h19;
  localparam logic [4:0]  DEST_HWS   = 5'h1B;
  localparam logic [15:0] IO_BASE    = 16'hFFC0;
  localparam logic [3:0]  CYC_SHORT  = 4'h4;
  localparam logic [3:0]  CYC_LONG   = 4'h6;
  localparam logic [1:0]  WORDS_TWO  = 2'h2;
  localparam logic [1:0]  WORDS_THREE = 2'h3;
  localparam logic [1:0]  PAD_INIT   = 2'h1;

  typedef enum logic {
    bitfield_toggle_op,
    bitfield_clear_op
  } bftm_op_t;

  typedef enum logic [2:0] {
    reg_direct_mode,
    short_absolute_mode,
    io_short_mode,
    index_offset_mode,
    stack_offset_mode,
    long_absolute_mode
  } bftm_mode_t;

  typedef enum logic [1:0] {
    space_reg,
    space_xmem,
    space_io
  } bftm_space_t;

  typedef struct packed {
    logic        req;
    logic        we;
    bftm_space_t space;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bftm_acc_t;

  function automatic logic [3:0] mode_cycles(input bftm_mode_t m);
    return (m == index_offset_mode || m == stack_offset_mode ||
            m == long_absolute_mode) ? CYC_LONG : CYC_SHORT;
  endfunction

  function automatic logic [1:0] mode_words(input bftm_mode_t m);
    return (m == long_absolute_mode) ? WORDS_THREE : WORDS_TWO;
  endfunction

endpackage

// >>> rtl/bftm_unit.sv
// bit-field test-and-modify unit with its register interface
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
module bftm_unit
  import bftm_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             dst_req,
  output logic             dst_we,
  output bftm_space_t      dst_space,
  output logic      [15:0] dst_addr,
  output logic      [15:0] dst_wdata,
  input  wire logic [15:0] dst_rdata,
  input  wire logic        dst_limit,
  output logic             busy,
  output logic      [15:0] status_register
);

  // ****************************************************************
  // parameter check
  // ****************************************************************
  generate
    if (DATA_W != 16) begin : g_bad_width
      $error("bftm_unit serves a 16-bit data path only");
    end
  endgenerate

  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_read,
    st_mod,
    st_write,
    st_fin
  } bftm_state_t;

  bftm_state_t state_q;
  bftm_op_t    op_q;
  bftm_mode_t  mode_q;
  logic [4:0]  dest_q;
  logic [15:0] mask_q;
  logic [15:0] opnd_q;
  logic [15:0] r2_q;
  logic [15:0] sp_q;
  logic [15:0] sr_q;
  logic [15:0] res_q;
  logic [1:0]  pad_q;
  logic        carry_q;
  logic        limit_q;
  logic        ill_q;
  logic        done_q;
  logic [3:0]  cyc_q;
  logic [1:0]  words_q;
  bftm_acc_t   acc_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  logic        setup;
  logic        wr_take;
  logic        mapped;
  logic        start;
  logic        is_sr;
  logic        refuse;
  bftm_mode_t  cur_mode;
  logic [4:0]  cur_dest;
  logic [15:0] rd_val;
  logic [15:0] mod_val;
  logic        all_set;
  bftm_space_t ea_space;
  logic [15:0] ea_addr;
  logic [31:0] rd_mux;

  // ****************************************************************
  // helpers
  // ****************************************************************
  bftm_addr u_addr (
    .mode  (cur_mode),
    .opnd  (opnd_q),
    .dest  (cur_dest),
    .r2    (r2_q),
    .sp    (sp_q),
    .space (ea_space),
    .addr  (ea_addr)
  );

  // in idle the fields come from the start write, not the old command
  assign cur_mode = (state_q == st_idle) ?
                    bftm_mode_t'(pwdata[CTRL_MODE+:3]) : mode_q;
  assign cur_dest = (state_q == st_idle) ? pwdata[CTRL_DEST+:5] : dest_q;
  assign refuse   = (cur_mode == reg_direct_mode) && (cur_dest == DEST_HWS);
  // status register as destination is read inside the unit
  assign is_sr  = (cur_mode == reg_direct_mode) && (cur_dest == DEST_SR);
  assign rd_val = is_sr ? sr_q : dst_rdata;

  bftm_modify #(
    .DATA_W (DATA_W)
  ) u_mod (
    .op      (op_q),
    .mask    (mask_q),
    .din     (rd_val),
    .dout    (mod_val),
    .all_set (all_set)
  );

  // ****************************************************************
  // apb slave
  // ****************************************************************
  assign setup   = psel && !penable;
  assign wr_take = psel && penable && pready_q && pwrite;
  assign mapped  = (paddr == CTRL_OFS) || (paddr == MASK_OFS) ||
                   (paddr == OPND_OFS) || (paddr == STAT_OFS) ||
                   (paddr == SREG_OFS) || (paddr == R2_OFS) ||
                   (paddr == SP_OFS);
  // a start is refused while a sequence runs
  assign start   = wr_take && (paddr == CTRL_OFS) &&
                   pwdata[CTRL_START] && (state_q == st_idle);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      CTRL_OFS: begin
        rd_mux[CTRL_OP]                = op_q;
        rd_mux[CTRL_MODE+:3]           = mode_q;
        rd_mux[CTRL_DEST+:5]           = dest_q;
      end
      MASK_OFS: rd_mux[15:0] = mask_q;
      OPND_OFS: rd_mux[15:0] = opnd_q;
      STAT_OFS: begin
        rd_mux[STAT_BUSY]      = (state_q != st_idle);
        rd_mux[STAT_CARRY]     = carry_q;
        rd_mux[STAT_LIMIT]     = limit_q;
        rd_mux[STAT_ILL]       = ill_q;
        rd_mux[STAT_DONE]      = done_q;
        rd_mux[STAT_CYC+:4]    = cyc_q;
        rd_mux[STAT_WORDS+:2]  = words_q;
      end
      SREG_OFS: rd_mux[15:0] = sr_q;
      R2_OFS:   rd_mux[15:0] = r2_q;
      SP_OFS:   rd_mux[15:0] = sp_q;
      default:  rd_mux = 32'h0000_0000;
    endcase
  end

  // no wait state: the answer is registered during setup
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (ce) begin
      if (setup) begin
        pready_q  <= 1'b1;
        pslverr_q <= !mapped;
        prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
      end else if (psel && penable && pready_q) begin
        pready_q  <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  // command registers, frozen while the unit is busy
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      op_q   <= bitfield_toggle_op;
      mode_q <= reg_direct_mode;
      dest_q <= 5'h00;
      mask_q <= REG_RESET;
      opnd_q <= REG_RESET;
      r2_q   <= REG_RESET;
      sp_q   <= REG_RESET;
    end else if (ce && wr_take && state_q == st_idle) begin
      case (paddr)
        CTRL_OFS: begin
          op_q   <= bftm_op_t'(pwdata[CTRL_OP]);
          mode_q <= bftm_mode_t'(pwdata[CTRL_MODE+:3]);
          dest_q <= pwdata[CTRL_DEST+:5];
        end
        MASK_OFS: mask_q <= pwdata[15:0];
        OPND_OFS: opnd_q <= pwdata[15:0];
        R2_OFS:   r2_q   <= pwdata[15:0];
        SP_OFS:   sp_q   <= pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_q <= st_idle;
      pad_q   <= 2'h0;
    end else if (ce) begin
      case (state_q)
        st_idle: begin
          if (start && !refuse) begin
            if (mode_cycles(cur_mode) == CYC_LONG) begin
              state_q <= st_addr;
              pad_q   <= PAD_INIT;
            end else begin
              state_q <= st_read;
            end
          end
        end
        st_addr: begin
          if (pad_q == 2'h0) begin
            state_q <= st_read;
          end else begin
            pad_q <= pad_q - 2'h1;
          end
        end
        st_read:  state_q <= st_mod;
        st_mod:   state_q <= st_write;
        st_write: state_q <= st_fin;
        st_fin:   state_q <= st_idle;
        default:  state_q <= st_idle;
      endcase
    end
  end

  // destination access: a read, then a write of the new value
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      acc_q <= '0;
    end else if (ce) begin
      acc_q.req <= 1'b0;
      acc_q.we  <= 1'b0;
      if (!is_sr && ((state_q == st_addr && pad_q == 2'h0) ||
          (state_q == st_idle && start && !refuse &&
           mode_cycles(cur_mode) == CYC_SHORT))) begin
        acc_q.req <= 1'b1;
      end
      // the address is latched with the request that first shows it
      if ((state_q == st_idle && start) || state_q == st_addr) begin
        acc_q.space <= ea_space;
        acc_q.addr  <= ea_addr;
      end
      if (state_q == st_mod && !is_sr) begin
        acc_q.req   <= 1'b1;
        acc_q.we    <= 1'b1;
        acc_q.wdata <= mod_val;
      end
    end
  end

  // result kept for a status register destination
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      res_q <= REG_RESET;
    end else if (ce && state_q == st_mod) begin
      res_q <= mod_val;
    end
  end

  // ****************************************************************
  // flags and status register
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sr_q <= SR_RESET;
    end else if (ce) begin
      if (state_q == st_write && is_sr) begin
        sr_q <= res_q;
      end else if (state_q == st_mod && !is_sr) begin
        sr_q[SR_C] <= all_set;
        if (mode_q == reg_direct_mode && dst_limit) begin
          sr_q[SR_L] <= 1'b1;
        end
      end else if (wr_take && paddr == SREG_OFS &&
                   state_q == st_idle) begin
        sr_q <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      carry_q <= 1'b0;
      limit_q <= 1'b0;
      ill_q   <= 1'b0;
      done_q  <= 1'b0;
      cyc_q   <= 4'h0;
      words_q <= 2'h0;
    end else if (ce) begin
      if (wr_take && paddr == CTRL_OFS && pwdata[CTRL_START] &&
          state_q == st_idle) begin
        ill_q   <= refuse;
        done_q  <= 1'b0;
        cyc_q   <= mode_cycles(cur_mode);
        words_q <= mode_words(cur_mode);
      end
      if (state_q == st_mod) begin
        carry_q <= all_set;
        limit_q <= !is_sr && mode_q == reg_direct_mode && dst_limit;
      end
      if (state_q == st_fin) begin
        done_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign dst_req         = acc_q.req;
  assign dst_we          = acc_q.we;
  assign dst_space       = acc_q.space;
  assign dst_addr        = acc_q.addr;
  assign dst_wdata       = acc_q.wdata;
  assign status_register = sr_q;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      busy <= 1'b0;
    end else if (ce) begin
      busy <= (state_q == st_idle) ? (start && !refuse)
                                   : (state_q != st_fin);
    end
  end

endmodule
